// ==== hdl/bcse_cipher_core.sv ====
// module: iterative 128-bit forward cipher core, one round per clock
`timescale 1ns/1ps
module bcse_cipher_core
(
    input wire logic clk_i, // core clock
    input wire logic rst_i, // synchronous reset, high
    bcse_cipher_if.core cif // start, operands and result
);

    typedef enum logic [1:0] {BCSE_CORE_IDLE = 2'b01, BCSE_CORE_ROUND = 2'b10} bcse_core_t;

    bcse_core_t state_r;
    logic [127:0] st_r;
    logic [127:0] rk_r;
    logic [3:0] rnd_r;
    logic [7:0] rcon_r;
    logic done_r;
    logic [127:0] nk;

    function automatic logic [7:0] xt(input logic [7:0] b);
        xt = {b[6:0], 1'b0} ^ (b[7] ? 8'h1b : 8'h00);
    endfunction : xt

    function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++)
        begin
            if (b[i])
                p = p ^ x;
            x = xt(x);
        end
        gm = p;
    endfunction : gm

    // substitution computed, not tabulated: inverse as b^254, then affine map
    function automatic logic [7:0] sb(input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] r;
        p = b;
        r = 8'h01;
        for (int i = 0; i < 7; i++)
        begin
            p = gm(p, p);
            r = gm(r, p);
        end
        sb = r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^ {r[3:0], r[7:4]} ^ 8'h63;
    endfunction : sb

    function automatic logic [127:0] next_key(input logic [127:0] k, input logic [7:0] rc);
        logic [31:0] w0;
        logic [31:0] w1;
        logic [31:0] w2;
        logic [31:0] w3;
        logic [31:0] t;
        w3 = k[31:0];
        t = {sb(w3[23:16]) ^ rc, sb(w3[15:8]), sb(w3[7:0]), sb(w3[31:24])};
        w0 = k[127:96] ^ t;
        w1 = k[95:64] ^ w0;
        w2 = k[63:32] ^ w1;
        next_key = {w0, w1, w2, w2 ^ w3};
    endfunction : next_key

    // substitute, shift rows, mix columns (skipped on the final round)
    function automatic logic [127:0] round_fn(input logic [127:0] s, input logic last);
        logic [7:0] b [16];
        logic [7:0] m [16];
        logic [127:0] r;
        for (int i = 0; i < 16; i++)
            b[i] = sb(s[127 - 8 * i -: 8]);
        for (int c = 0; c < 4; c++)
            for (int rw = 0; rw < 4; rw++)
                m[4 * c + rw] = b[4 * ((c + rw) % 4) + rw];
        for (int c = 0; c < 4; c++)
        begin
            r[127 - 32 * c -: 8] = last ? m[4 * c] : xt(m[4 * c]) ^ gm(m[4 * c + 1], 8'h03)
                ^ m[4 * c + 2] ^ m[4 * c + 3];
            r[119 - 32 * c -: 8] = last ? m[4 * c + 1] : m[4 * c] ^ xt(m[4 * c + 1])
                ^ gm(m[4 * c + 2], 8'h03) ^ m[4 * c + 3];
            r[111 - 32 * c -: 8] = last ? m[4 * c + 2] : m[4 * c] ^ m[4 * c + 1]
                ^ xt(m[4 * c + 2]) ^ gm(m[4 * c + 3], 8'h03);
            r[103 - 32 * c -: 8] = last ? m[4 * c + 3] : gm(m[4 * c], 8'h03) ^ m[4 * c + 1]
                ^ m[4 * c + 2] ^ xt(m[4 * c + 3]);
        end
        round_fn = r;
    endfunction : round_fn

    assign nk = next_key(rk_r, rcon_r);

    // iterate: key add on start, then ten rounds with on-the-fly key schedule
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= BCSE_CORE_IDLE;
            st_r <= bcse_pkg::RST_BLOCK;
            rk_r <= bcse_pkg::RST_BLOCK;
            rnd_r <= 4'h0;
            rcon_r <= 8'h01;
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            unique case (state_r)
                BCSE_CORE_IDLE:
                begin
                    if (cif.start)
                    begin
                        st_r <= cif.block_in ^ cif.key;
                        rk_r <= cif.key;
                        rnd_r <= 4'h1;
                        rcon_r <= 8'h01;
                        state_r <= BCSE_CORE_ROUND;
                    end
                end
                BCSE_CORE_ROUND:
                begin
                    st_r <= round_fn(st_r, rnd_r == 4'(bcse_pkg::CIPHER_ROUNDS)) ^ nk;
                    rk_r <= nk;
                    rcon_r <= xt(rcon_r);
                    rnd_r <= rnd_r + 4'h1;
                    if (rnd_r == 4'(bcse_pkg::CIPHER_ROUNDS))
                    begin
                        done_r <= 1'b1;
                        state_r <= BCSE_CORE_IDLE;
                    end
                end
            endcase
        end
    end

    assign cif.done = done_r;
    assign cif.block_out = st_r;

endmodule : bcse_cipher_core

// ==== hdl/bcse_cipher_if.sv ====
// interface: control-to-core link of the block cipher engine
`timescale 1ns/1ps
interface bcse_cipher_if;
    logic start;
    logic [127:0] key;
    logic [127:0] block_in;
    logic done;
    logic [127:0] block_out;

    modport ctl (output start, output key, output block_in, input done, input block_out);
    modport core (input start, input key, input block_in, output done, output block_out);
endinterface : bcse_cipher_if

// ==== hdl/bcse_engine.sv ====
// module: block cipher security engine with wishbone register slave
//
// Behaviour
// - start bit launches a conversion and clears itself with no further write
// - engine stays disabled after reset until a self-test has passed
// - pass sets test-passed bit; fail clears it, disables, zeroes outputs
// - self-test may be rerun on software request whenever the engine is idle
// - selector in bits 7:5 of control two picks the data window field
// - counter result readable eleven clocks after start
// - completion sets the done bit in interrupt status two
// - counter decryption uses the same forward cipher path
// - authentication value readable eleven clocks after start, twenty-two when counter runs first
// - with counter and chaining bits set, counter runs first, then chaining
// - counter and chaining results kept in separate selectable registers
// - plain cipher has no feedback; result ready eleven clocks after start
// - 128-bit blocks only, no inverse cipher offered
// - selector 000 key, 001 text, 010 counter
// - selector 011 counter result, 100 chaining, 101 preload, 110 plain result
// - self-clearing clear bit zeroes counter and chaining result registers
// - chaining mode xors text with previous block output before the cipher
`timescale 1ns/1ps
module bcse_engine
(
    input wire logic clk_i, // system clock, 200 MHz
    input wire logic rst_i, // synchronous reset, high
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write enable
    input wire logic [7:0] wb_adr_i, // wishbone byte address
    input wire logic [3:0] wb_sel_i, // wishbone byte enables
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    output logic busy_o, // conversion in progress
    output logic selftest_passed_o // last self-test passed
);

    typedef enum logic [4:0]
    {
        BCSE_IDLE = 5'b00001,
        BCSE_RUN_CTR = 5'b00010,
        BCSE_RUN_CBC = 5'b00100,
        BCSE_RUN_AES = 5'b01000,
        BCSE_RUN_TEST = 5'b10000
    } bcse_state_t;

    bcse_state_t state_r;
    bcse_state_t state_nxt;

    bcse_cipher_if cif();

    // software-visible state
    logic ctr_mode_r;
    logic cbc_mode_r;
    logic aes_mode_r;
    logic selftest_mode_r;
    logic [2:0] sel_r;
    logic selftest_passed_r;
    logic enabled_r;
    logic done_irq_r;
    logic [127:0] key_r;
    logic [127:0] text_r;
    logic [127:0] counter_r;
    logic [127:0] preload_r;
    logic [127:0] ctr_result_r;
    logic [127:0] cbc_result_r;

    // bus slave state
    logic ack_r;
    logic [31:0] rdata_r;

    logic wr_stb;
    logic wr_ctl1;
    logic wr_ctl2;
    logic wr_irq;
    logic wr_data;
    logic [3:0] data_idx;
    logic start_req;
    logic clear_req;
    logic preload_req;
    logic conv_done;
    logic test_ok;
    logic [7:0] rd_byte;
    logic [127:0] win_field;

    // byte i of a block sits at bits 127-8i downto 120-8i
    function automatic logic [7:0] get_byte(input logic [127:0] f, input logic [3:0] i);
        get_byte = f[127 - 8 * i -: 8];
    endfunction : get_byte

    function automatic logic [127:0] put_byte(input logic [127:0] f, input logic [3:0] i,
        input logic [7:0] v);
        logic [127:0] r;
        r = f;
        r[127 - 8 * i -: 8] = v;
        put_byte = r;
    endfunction : put_byte

    // write takes effect at the edge where the master samples ack
    assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];
    assign wr_ctl1 = wr_stb && (wb_adr_i == bcse_pkg::OFS_CONTROL_ONE);
    assign wr_ctl2 = wr_stb && (wb_adr_i == bcse_pkg::OFS_CONTROL_TWO);
    assign wr_irq = wr_stb && (wb_adr_i == bcse_pkg::OFS_IRQ_STATUS_TWO);
    assign wr_data = wr_stb && (wb_adr_i >= bcse_pkg::OFS_DATA_BASE)
        && (wb_adr_i <= bcse_pkg::OFS_DATA_LAST) && (wb_adr_i[1:0] == 2'b00);
    assign data_idx = 4'((wb_adr_i - bcse_pkg::OFS_DATA_BASE) >> 2);

    // start, clear and preload are pulses, never stored as bits
    assign start_req = wr_ctl1 && wb_dat_i[bcse_pkg::C1_START];
    assign clear_req = wr_ctl1 && wb_dat_i[bcse_pkg::C1_CLEAR];
    assign preload_req = wr_ctl1 && wb_dat_i[bcse_pkg::C1_PRELOAD];
    assign conv_done = cif.done;
    assign test_ok = (cif.block_out == bcse_pkg::TEST_EXPECT);

    // sequencer: a start while busy is ignored, the current job finishes first
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            BCSE_IDLE:
            begin
                if (start_req)
                begin
                    if (wb_dat_i[bcse_pkg::C1_SELFTEST])
                        state_nxt = BCSE_RUN_TEST;
                    else if (!enabled_r)
                        state_nxt = BCSE_IDLE;
                    else if (wb_dat_i[bcse_pkg::C1_CTR])
                        state_nxt = BCSE_RUN_CTR;
                    else if (wb_dat_i[bcse_pkg::C1_CBC])
                        state_nxt = BCSE_RUN_CBC;
                    else if (wb_dat_i[bcse_pkg::C1_AES])
                        state_nxt = BCSE_RUN_AES;
                end
            end
            BCSE_RUN_CTR:
            begin
                if (conv_done)
                    state_nxt = cbc_mode_r ? BCSE_RUN_CBC : BCSE_IDLE;
            end
            BCSE_RUN_CBC, BCSE_RUN_AES, BCSE_RUN_TEST:
            begin
                if (conv_done)
                    state_nxt = BCSE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_r <= BCSE_IDLE;
        else
            state_r <= state_nxt;
    end

    // core launch: on a start from idle, or chaining leg right after counter leg
    assign cif.start = (state_r == BCSE_IDLE && state_nxt != BCSE_IDLE)
        || (state_r == BCSE_RUN_CTR && state_nxt == BCSE_RUN_CBC);

    // operand routing per the leg being launched
    always_comb
    begin
        cif.key = key_r;
        cif.block_in = text_r;
        if (state_nxt == BCSE_RUN_TEST)
        begin
            cif.key = bcse_pkg::TEST_KEY;
            cif.block_in = bcse_pkg::TEST_TEXT;
        end
        else if (state_nxt == BCSE_RUN_CTR)
            cif.block_in = counter_r;
        else if (state_nxt == BCSE_RUN_CBC)
            cif.block_in = text_r ^ cbc_result_r;
    end

    bcse_cipher_core u_core
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cif(cif)
    );

    // control register one: static mode bits; start, clear, preload self-clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctr_mode_r <= bcse_pkg::RST_CONTROL_ONE[bcse_pkg::C1_CTR];
            cbc_mode_r <= bcse_pkg::RST_CONTROL_ONE[bcse_pkg::C1_CBC];
            aes_mode_r <= bcse_pkg::RST_CONTROL_ONE[bcse_pkg::C1_AES];
            selftest_mode_r <= bcse_pkg::RST_CONTROL_ONE[bcse_pkg::C1_SELFTEST];
        end
        else if (wr_ctl1)
        begin
            ctr_mode_r <= wb_dat_i[bcse_pkg::C1_CTR];
            cbc_mode_r <= wb_dat_i[bcse_pkg::C1_CBC];
            aes_mode_r <= wb_dat_i[bcse_pkg::C1_AES];
            selftest_mode_r <= wb_dat_i[bcse_pkg::C1_SELFTEST];
        end
    end

    // control register two: window selector
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sel_r <= bcse_pkg::RST_SEL;
        else if (wr_ctl2)
            sel_r <= wb_dat_i[bcse_pkg::C2_SEL_HI:bcse_pkg::C2_SEL_LO];
    end

    // self-test verdict gates non-test conversion starts and result reads
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            selftest_passed_r <= 1'b0;
            enabled_r <= 1'b0;
        end
        else if (state_r == BCSE_RUN_TEST && conv_done)
        begin
            selftest_passed_r <= test_ok;
            enabled_r <= test_ok;
        end
    end

    // done flag: hardware set wins over a same-cycle write-one clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            done_irq_r <= 1'b0;
        else if (conv_done && state_nxt == BCSE_IDLE)
            done_irq_r <= 1'b1;
        else if (wr_irq && wb_dat_i[bcse_pkg::IS2_DONE])
            done_irq_r <= 1'b0;
    end

    // input fields, written byte by byte through the window
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            key_r <= bcse_pkg::RST_BLOCK;
            text_r <= bcse_pkg::RST_BLOCK;
            counter_r <= bcse_pkg::RST_BLOCK;
            preload_r <= bcse_pkg::RST_BLOCK;
        end
        else if (wr_data)
        begin
            unique case (sel_r)
                bcse_pkg::SEL_KEY: key_r <= put_byte(key_r, data_idx, wb_dat_i[7:0]);
                bcse_pkg::SEL_TEXT: text_r <= put_byte(text_r, data_idx, wb_dat_i[7:0]);
                bcse_pkg::SEL_COUNTER: counter_r <= put_byte(counter_r, data_idx, wb_dat_i[7:0]);
                bcse_pkg::SEL_PRELOAD: preload_r <= put_byte(preload_r, data_idx, wb_dat_i[7:0]);
                default: ; // result fields are read only
            endcase
        end
    end

    // counter result: own register, cleared by the clear pulse
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctr_result_r <= bcse_pkg::RST_BLOCK;
        else if (state_r == BCSE_RUN_CTR && conv_done)
            ctr_result_r <= cif.block_out ^ text_r;
        else if (clear_req)
            ctr_result_r <= bcse_pkg::RST_BLOCK;
    end

    // chaining accumulator, also holds plain results to save a register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cbc_result_r <= bcse_pkg::RST_BLOCK;
        else if ((state_r == BCSE_RUN_CBC || state_r == BCSE_RUN_AES) && conv_done)
            cbc_result_r <= cif.block_out;
        else if (state_r == BCSE_RUN_TEST && conv_done)
            cbc_result_r <= cif.block_out; // leaves a residue; software clears it
        else if (clear_req)
            cbc_result_r <= bcse_pkg::RST_BLOCK;
        else if (preload_req)
            cbc_result_r <= preload_r;
    end

    // window field for reads; results read zero while disabled
    always_comb
    begin
        win_field = bcse_pkg::RST_BLOCK;
        unique case (sel_r)
            bcse_pkg::SEL_KEY: win_field = key_r;
            bcse_pkg::SEL_TEXT: win_field = text_r;
            bcse_pkg::SEL_COUNTER: win_field = counter_r;
            bcse_pkg::SEL_CTR_RESULT: win_field = enabled_r ? ctr_result_r : '0;
            bcse_pkg::SEL_CBC_RESULT: win_field = enabled_r ? cbc_result_r : '0;
            bcse_pkg::SEL_PRELOAD: win_field = preload_r;
            bcse_pkg::SEL_AES_RESULT: win_field = enabled_r ? cbc_result_r : '0;
            default: win_field = bcse_pkg::RST_BLOCK;
        endcase
        rd_byte = get_byte(win_field, data_idx);
    end

    // read mux; unmapped addresses answer zero with a normal ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_r <= 32'h0;
        else if (wb_cyc_i && wb_stb_i && !ack_r)
        begin
            rdata_r <= 32'h0;
            if (wb_adr_i == bcse_pkg::OFS_CONTROL_ONE)
            begin
                rdata_r[bcse_pkg::C1_START] <= (state_r != BCSE_IDLE);
                rdata_r[bcse_pkg::C1_CTR] <= ctr_mode_r;
                rdata_r[bcse_pkg::C1_CBC] <= cbc_mode_r;
                rdata_r[bcse_pkg::C1_AES] <= aes_mode_r;
                rdata_r[bcse_pkg::C1_SELFTEST] <= selftest_mode_r;
            end
            else if (wb_adr_i == bcse_pkg::OFS_CONTROL_TWO)
            begin
                rdata_r[bcse_pkg::C2_SEL_HI:bcse_pkg::C2_SEL_LO] <= sel_r;
                rdata_r[bcse_pkg::C2_PASSED] <= selftest_passed_r;
            end
            else if (wb_adr_i == bcse_pkg::OFS_IRQ_STATUS_TWO)
                rdata_r[bcse_pkg::IS2_DONE] <= done_irq_r;
            else if (wb_adr_i >= bcse_pkg::OFS_DATA_BASE && wb_adr_i <= bcse_pkg::OFS_DATA_LAST
                && wb_adr_i[1:0] == 2'b00)
                rdata_r[7:0] <= rd_byte;
        end
    end

    // ack one cycle after request, dropped the cycle after it is given
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;
    assign busy_o = (state_r != BCSE_IDLE);
    assign selftest_passed_o = selftest_passed_r;

endmodule : bcse_engine

// ==== hdl/bcse_pkg.sv ====
// package: register map, field positions and constants of the block cipher engine
package bcse_pkg;

    // register byte offsets on the wishbone bus
    localparam logic [7:0] OFS_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFS_CONTROL_TWO = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS_TWO = 8'h08;
    localparam logic [7:0] OFS_DATA_BASE = 8'h10;
    localparam logic [7:0] OFS_DATA_LAST = 8'h4c;

    // cipher_control_one field positions
    localparam int C1_START = 0;
    localparam int C1_CLEAR = 1;
    localparam int C1_PRELOAD = 2;
    localparam int C1_CTR = 3;
    localparam int C1_CBC = 4;
    localparam int C1_AES = 5;
    localparam int C1_SELFTEST = 6;

    // cipher_control_two field positions
    localparam int C2_PASSED = 0;
    localparam int C2_SEL_LO = 5;
    localparam int C2_SEL_HI = 7;

    // interrupt_status_two field position
    localparam int IS2_DONE = 0;

    // data window selector codes
    localparam logic [2:0] SEL_KEY = 3'h0;
    localparam logic [2:0] SEL_TEXT = 3'h1;
    localparam logic [2:0] SEL_COUNTER = 3'h2;
    localparam logic [2:0] SEL_CTR_RESULT = 3'h3;
    localparam logic [2:0] SEL_CBC_RESULT = 3'h4;
    localparam logic [2:0] SEL_PRELOAD = 3'h5;
    localparam logic [2:0] SEL_AES_RESULT = 3'h6;

    // reset values
    localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
    localparam logic [2:0] RST_SEL = 3'h0;
    localparam logic [127:0] RST_BLOCK = 128'h0;

    // cipher timing: one key-add cycle plus ten rounds
    localparam int CIPHER_ROUNDS = 10;
    localparam int CONV_CYCLES = 11;

    // known-answer vector for the built-in self-test
    localparam logic [127:0] TEST_KEY = 128'h000102030405060708090a0b0c0d0e0f;
    localparam logic [127:0] TEST_TEXT = 128'h00112233445566778899aabbccddeeff;
    localparam logic [127:0] TEST_EXPECT = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;

endpackage : bcse_pkg

// ==== test/bcse_monitor.sv ====
// checker: bus answer and conversion timing of the cipher engine
`timescale 1ns/1ps
module bcse_monitor
(
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [7:0] wb_adr_i, // address
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // ack
    input wire logic busy_o, // busy
    input wire logic selftest_passed_o // verdict
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // start write applied at the ack edge while idle
    sequence s_go;
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00 && wb_dat_i[0] && !busy_o;
    endsequence
    // read answered at the ack edge
    sequence s_rd;
        wb_ack_o && !wb_we_i;
    endsequence
    // one cipher leg: eleven busy cycles in a row
    sequence s_leg;
        busy_o[*8] ##1 busy_o[*3];
    endsequence
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack did not follow request");
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_start_sets_busy: assert property (s_go ##0 wb_dat_i[6] |=> busy_o)
        else $error("self-test start did not begin");
    a_locked_no_start: assert property (s_go ##0 !wb_dat_i[6] && !selftest_passed_o
        |=> !busy_o)
        else $error("conversion began while disabled");
    a_conv_eleven: assert property ($rose(busy_o) |-> s_leg ##1
        (!busy_o or (busy_o[*8] ##1 busy_o[*3] ##1 !busy_o)))
        else $error("conversion length wrong");
    a_verdict_at_end: assert property ($changed(selftest_passed_o) |-> $fell(busy_o))
        else $error("verdict changed outside conversion end");
    a_start_reads_busy: assert property (s_rd ##0 wb_adr_i == 8'h00
        |-> wb_dat_o[0] == $past(busy_o))
        else $error("start bit does not read busy");
    a_upper_bits_zero: assert property (s_rd |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_unmapped_zero: assert property (s_rd ##0 wb_adr_i > 8'h4c |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
endmodule : bcse_monitor

bind bcse_engine bcse_monitor bcse_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .busy_o(busy_o), .selftest_passed_o(selftest_passed_o));

// ==== test/tb_top.sv ====
// testbench: register-level tests of the cipher engine
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic busy_o;
    logic selftest_passed_o;
    logic [31:0] rd_q;
    int mismatches = 0;
    int checks = 0;
    localparam logic [127:0] TXT = bcse_pkg::TEST_TEXT;
    localparam logic [127:0] EXP = bcse_pkg::TEST_EXPECT;
    localparam logic [127:0] T2 = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;
    bcse_engine bcse_engine_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o),
        .selftest_passed_o(selftest_passed_o));
    task print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task fail_wait;
        mismatches++;
        $display("unexpected at %0t: wait ran out", $time);
        print_verdict();
    endtask : fail_wait
    task cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask : cmp32
    task cmp128(input logic [127:0] got, input logic [127:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: block %h, wanted %h", $time, got, exp);
        end
    endtask : cmp128
    // one classic cycle; entered just after an edge, leaves one idle cycle
    task xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20)
            fail_wait();
        rd_q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : xfer
    task rdc(input logic [7:0] adr, input logic [31:0] exp);
        xfer(1'b0, adr, 32'h0);
        cmp32(rd_q, exp);
    endtask : rdc
    // byte i of the window is bits 127-8i downwards
    task ld(input logic [2:0] sel, input logic [127:0] v);
        xfer(1'b1, 8'h04, {24'h0, sel, 5'h0});
        for (int i = 0; i < 16; i++)
            xfer(1'b1, 8'h10 + 8'(4 * i), {24'h0, v[127 - 8 * i -: 8]});
    endtask : ld
    task chk_blk(input logic [2:0] sel, input logic [127:0] exp);
        logic [127:0] got;
        xfer(1'b1, 8'h04, {24'h0, sel, 5'h0});
        for (int i = 0; i < 16; i++)
        begin
            xfer(1'b0, 8'h10 + 8'(4 * i), 32'h0);
            got[127 - 8 * i -: 8] = rd_q[7:0];
        end
        cmp128(got, exp);
    endtask : chk_blk
    // write control one, then wait out any conversion
    task run(input logic [7:0] c);
        int n;
        n = 0;
        xfer(1'b1, 8'h00, {24'h0, c});
        while (busy_o === 1'b1 && n < 40)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 40)
            fail_wait();
    endtask : run
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h0);
        rdc(8'h08, 32'h0);
        rdc(8'h80, 32'h0);
        $display("test reset done");
        ld(bcse_pkg::SEL_KEY, bcse_pkg::TEST_KEY);
        chk_blk(bcse_pkg::SEL_KEY, bcse_pkg::TEST_KEY);
        ld(bcse_pkg::SEL_COUNTER, TXT);
        run(8'h09);
        rdc(8'h08, 32'h0);
        $display("test locked done");
        run(8'h41);
        cmp32({31'h0, selftest_passed_o}, 32'h1);
        rdc(8'h04, 32'h41);
        rdc(8'h08, 32'h1);
        xfer(1'b1, 8'h08, 32'h1);
        rdc(8'h08, 32'h0);
        run(8'h00);
        $display("test selftest done");
        ld(bcse_pkg::SEL_TEXT, TXT);
        xfer(1'b1, 8'h00, 32'h21);
        rdc(8'h00, 32'h21);
        run(8'h21);
        rdc(8'h00, 32'h20);
        chk_blk(bcse_pkg::SEL_AES_RESULT, EXP);
        chk_blk(bcse_pkg::SEL_CBC_RESULT, EXP);
        $display("test plain done");
        ld(bcse_pkg::SEL_TEXT, T2);
        run(8'h09);
        chk_blk(bcse_pkg::SEL_CTR_RESULT, EXP ^ T2);
        ld(bcse_pkg::SEL_TEXT, EXP ^ T2);
        run(8'h09);
        chk_blk(bcse_pkg::SEL_CTR_RESULT, T2);
        $display("test counter done");
        run(8'h02);
        chk_blk(bcse_pkg::SEL_CBC_RESULT, 128'h0);
        chk_blk(bcse_pkg::SEL_CTR_RESULT, 128'h0);
        ld(bcse_pkg::SEL_TEXT, TXT);
        run(8'h11);
        chk_blk(bcse_pkg::SEL_CBC_RESULT, EXP);
        ld(bcse_pkg::SEL_TEXT, TXT ^ EXP);
        run(8'h11);
        chk_blk(bcse_pkg::SEL_CBC_RESULT, EXP);
        ld(bcse_pkg::SEL_PRELOAD, T2);
        run(8'h04);
        chk_blk(bcse_pkg::SEL_CBC_RESULT, T2);
        chk_blk(bcse_pkg::SEL_PRELOAD, T2);
        $display("test chaining done");
        run(8'h02);
        ld(bcse_pkg::SEL_TEXT, TXT);
        run(8'h19);
        chk_blk(bcse_pkg::SEL_CTR_RESULT, EXP ^ TXT);
        chk_blk(bcse_pkg::SEL_CBC_RESULT, EXP);
        $display("test combined done");
        run(8'h41);
        cmp32({31'h0, selftest_passed_o}, 32'h1);
        chk_blk(bcse_pkg::SEL_CBC_RESULT, EXP);
        run(8'h00);
        $display("test rerun done");
        print_verdict();
    end
endmodule : tb_top
